// ===== hdl/gpc_pkg.sv
// Package: register map, configuration field positions, reset values and timing for the gauge pin logic
package gpc_pkg;

    // Register byte addresses on APB
    localparam logic [11:0] ADDR_OPCFG   = 12'h000;
    localparam logic [11:0] ADDR_OPCFG_B = 12'h004;
    localparam logic [11:0] ADDR_CTRL    = 12'h008;
    localparam logic [11:0] ADDR_STATUS  = 12'h00C;
    localparam logic [11:0] ADDR_LOCATE  = 12'h010;

    // Nonvolatile location of the configuration word
    localparam logic [7:0]  NV_SUBCLASS  = 8'h40;
    localparam logic [7:0]  NV_OFFSET    = 8'h00;

    // Operation configuration word field positions (high byte = bits 15:8)
    localparam int OC_RES_COMP = 15;
    localparam int OC_GOOD_OVR = 14;
    localparam int OC_REFUSE   = 13;
    localparam int OC_FUNC_HI  = 12;
    localparam int OC_FUNC_LO  = 11;
    localparam int OC_WAKE     = 10;
    localparam int OC_RSNS_HI  = 9;
    localparam int OC_RSNS_LO  = 8;
    localparam int OC_GND_SEL  = 7;
    localparam int OC_PROFSEL  = 6;
    localparam int OC_SLEEP    = 5;
    localparam int OC_RELOAD   = 4;
    localparam int OC_LOW_POL  = 3;
    localparam int OC_GOOD_POL = 2;
    localparam int OC_FN       = 1;
    localparam int OC_TEMP_SRC = 0;
    localparam logic [15:0] OPCFG_RESET = 16'h0979;

    // Extension word
    localparam int OB_RSTEP   = 7;
    localparam int OB_SLPWAKE = 6;
    localparam logic [7:0] OPCFG_B_RESET = 8'h40;

    // Control register bits
    localparam int CT_OCV_DONE = 0;
    localparam int CT_HIB_VOLT = 1;
    localparam int CT_HIBERN   = 2;
    localparam int CT_TERM     = 3;

    // Pin function codes
    localparam logic [1:0] PIN_MODE0 = 2'b00;
    localparam logic [1:0] PIN_MODE1 = 2'b01;
    localparam logic [1:0] PIN_MODE2 = 2'b10;

    // Presence poll period
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          POLL_PERIOD_S = 1;
    localparam int          POLL_CYCLES   = CLK_HZ * POLL_PERIOD_S;
    localparam logic [23:0] POLL_COUNT    = 24'(POLL_CYCLES - 1);

    // Extra wake charge time
    localparam int WAKE_CHARGE_S = 10;

    typedef enum logic [2:0] {
        GPC_NO_BATT = 3'b001,
        GPC_WAIT_OCV = 3'b010,
        GPC_GOOD    = 3'b100
    } gpc_batt_state_t;

    // Configuration fields steering the rest of the gauge
    typedef struct packed {
        logic       reserve_noload_comp;
        logic       flash_update_refuse;
        logic [1:0] pin_function_code;
        logic       current_wake_level;
        logic [1:0] sense_range;
        logic       adc_ground_choice;
        logic       profile_select_enable;
        logic       sleep_allowed;
        logic       capacity_reload_on_full;
        logic       temp_source_select;
        logic       resistance_step_limit;
        logic       sleep_wake_charge_add;
    } gpc_cfg_t;

    // Thermal, sleep and capacity reload requests toward the gauge engine
    typedef struct packed {
        logic measure_temp;
        logic use_thermistor;
        logic sleep_enter;
        logic reload_capacity;
    } gpc_ctl_t;

endpackage : gpc_pkg

// ===== hdl/gpc_pin_status.sv
// Gauge pin configuration registers, status pin multiplexer and battery presence poll
`timescale 1ns/1ps
module gpc_pin_status (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 charge_state_threshold_flag,
    input  wire logic                 charging,
    input  wire logic                 flash_update_busy,
    input  wire logic                 sleep_conditions_ok,
    input  wire logic                 temp_outside_inhibit,
    input  wire logic                 temp_inside_hys_band,
    input  wire logic                 thermistor_near_open,
    input  wire logic                 battery_insert_pin_in,
    output logic                      battery_insert_pin_out,
    output logic                      battery_insert_pin_oe_n,
    output logic                      status_pin_out,
    output logic                      status_pin_oe_n,
    output logic                      bus_refuse,
    output logic                      bus_stretch,
    output logic                      battery_detected_flag,
    output gpc_pkg::gpc_cfg_t         cfg,
    output gpc_pkg::gpc_ctl_t         ctl
);

    logic [15:0]              op_cfg;
    logic [7:0]               op_cfg_b;
    logic [3:0]               ctrl;
    logic [23:0]              poll_cnt;
    logic                     poll_tick;
    logic                     inhibit;
    logic                     battery_low_output;
    logic                     battery_good_output;
    logic                     good_active;
    logic                     present_seen;
    logic [1:0]               pin_function_code;
    logic                     wr_en;
    gpc_pkg::gpc_batt_state_t state;
    gpc_pkg::gpc_batt_state_t next_state;

    assign pin_function_code = {op_cfg[gpc_pkg::OC_FUNC_HI], op_cfg[gpc_pkg::OC_FUNC_LO]};
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // Configuration word registers
    always_ff @(posedge clock) begin
        if (reset) begin
            op_cfg   <= gpc_pkg::OPCFG_RESET;
            op_cfg_b <= gpc_pkg::OPCFG_B_RESET;
        end else if (wr_en) begin
            if (paddr == gpc_pkg::ADDR_OPCFG) begin
                op_cfg <= pwdata[15:0];
            end
            if (paddr == gpc_pkg::ADDR_OPCFG_B) begin
                op_cfg_b <= pwdata[7:0];
            end
        end
    end

    // Gauge-engine events written by firmware
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl <= 4'h0;
        end else if (wr_en && paddr == gpc_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[3:0];
        end else begin
            ctrl[gpc_pkg::CT_TERM] <= 1'b0;
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                gpc_pkg::ADDR_OPCFG:   prdata <= {16'h0000, op_cfg};
                gpc_pkg::ADDR_OPCFG_B: prdata <= {24'h00_0000, op_cfg_b};
                gpc_pkg::ADDR_CTRL:    prdata <= {28'h000_0000, ctrl};
                gpc_pkg::ADDR_STATUS:  prdata <= {25'h000_0000, state, inhibit,
                                                  battery_detected_flag, status_pin_out,
                                                  battery_insert_pin_in};
                gpc_pkg::ADDR_LOCATE:  prdata <= {16'h0000, gpc_pkg::NV_SUBCLASS,
                                                  gpc_pkg::NV_OFFSET};
                default:               prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Configuration fan-out
    always_comb begin
        cfg.reserve_noload_comp     = op_cfg[gpc_pkg::OC_RES_COMP];
        cfg.flash_update_refuse     = op_cfg[gpc_pkg::OC_REFUSE];
        cfg.pin_function_code       = pin_function_code;
        cfg.current_wake_level      = op_cfg[gpc_pkg::OC_WAKE];
        cfg.sense_range             = {op_cfg[gpc_pkg::OC_RSNS_HI],
                                       op_cfg[gpc_pkg::OC_RSNS_LO]};
        cfg.adc_ground_choice       = op_cfg[gpc_pkg::OC_GND_SEL];
        cfg.profile_select_enable   = op_cfg[gpc_pkg::OC_PROFSEL];
        cfg.sleep_allowed           = op_cfg[gpc_pkg::OC_SLEEP];
        cfg.capacity_reload_on_full = op_cfg[gpc_pkg::OC_RELOAD];
        cfg.temp_source_select      = op_cfg[gpc_pkg::OC_TEMP_SRC];
        cfg.resistance_step_limit   = op_cfg_b[gpc_pkg::OB_RSTEP];
        cfg.sleep_wake_charge_add   = op_cfg_b[gpc_pkg::OB_SLPWAKE];
    end

    // Requests toward the gauge engine
    always_comb begin
        // Temperature is skipped during charge only in mode 2
        ctl.measure_temp    = !(pin_function_code == gpc_pkg::PIN_MODE2 && charging);
        ctl.use_thermistor  = op_cfg[gpc_pkg::OC_TEMP_SRC];
        ctl.sleep_enter     = op_cfg[gpc_pkg::OC_SLEEP] && sleep_conditions_ok;
        ctl.reload_capacity = op_cfg[gpc_pkg::OC_RELOAD] && ctrl[gpc_pkg::CT_TERM];
    end

    // Flash update bus response
    assign bus_refuse  = flash_update_busy && op_cfg[gpc_pkg::OC_REFUSE];
    assign bus_stretch = flash_update_busy && !op_cfg[gpc_pkg::OC_REFUSE];

    // One-second poll tick
    always_ff @(posedge clock) begin
        if (reset || poll_tick) begin
            poll_cnt <= 24'h00_0000;
        end else begin
            poll_cnt <= poll_cnt + 24'h00_0001;
        end
    end
    assign poll_tick = (poll_cnt == gpc_pkg::POLL_COUNT);

    // Insert pin is never driven, only sensed through its pull-up
    assign battery_insert_pin_out  = 1'b0;
    assign battery_insert_pin_oe_n = 1'b1;
    assign present_seen = !battery_insert_pin_in && !thermistor_near_open;

    // Battery presence and good sequence
    always_comb begin
        next_state = state;
        unique case (state)
            gpc_pkg::GPC_NO_BATT: begin
                if (poll_tick && present_seen) begin
                    next_state = gpc_pkg::GPC_WAIT_OCV;
                end
            end
            gpc_pkg::GPC_WAIT_OCV: begin
                if (poll_tick && !present_seen
                    && !(pin_function_code == gpc_pkg::PIN_MODE2 && charging)) begin
                    next_state = gpc_pkg::GPC_NO_BATT;
                end else if (ctrl[gpc_pkg::CT_OCV_DONE]) begin
                    next_state = gpc_pkg::GPC_GOOD;
                end
            end
            gpc_pkg::GPC_GOOD: begin
                // Removal while charging in mode 2 keeps detection set
                if (poll_tick && !present_seen
                    && !(pin_function_code == gpc_pkg::PIN_MODE2 && charging)) begin
                    next_state = gpc_pkg::GPC_NO_BATT;
                end
            end
            default: next_state = gpc_pkg::GPC_NO_BATT;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= gpc_pkg::GPC_NO_BATT;
        end else begin
            state <= next_state;
        end
    end

    assign battery_detected_flag = (state != gpc_pkg::GPC_NO_BATT);

    // Charge inhibit with hysteresis, mode 1 only
    always_ff @(posedge clock) begin
        if (reset || pin_function_code != gpc_pkg::PIN_MODE1) begin
            inhibit <= 1'b0;
        end else if (temp_outside_inhibit) begin
            inhibit <= 1'b1;
        end else if (temp_inside_hys_band) begin
            inhibit <= 1'b0;
        end
    end

    // Good is asserted once the reading is valid; in voltage-only hibernation the override holds it
    always_comb begin
        good_active = (state == gpc_pkg::GPC_GOOD);
        if (ctrl[gpc_pkg::CT_HIBERN] && !(ctrl[gpc_pkg::CT_HIB_VOLT]
                                          && op_cfg[gpc_pkg::OC_GOOD_OVR])) begin
            good_active = 1'b0;
        end
    end

    // Pin levels per polarity bits
    assign battery_low_output  = op_cfg[gpc_pkg::OC_LOW_POL] ? charge_state_threshold_flag
                                                              : !charge_state_threshold_flag;
    assign battery_good_output = op_cfg[gpc_pkg::OC_GOOD_POL] ? good_active
                                                               : !good_active;

    // Status pin register; high level is released to the pull-up
    always_ff @(posedge clock) begin
        if (reset) begin
            status_pin_out <= 1'b1;
        end else if (inhibit) begin
            status_pin_out <= 1'b1;
        end else if (op_cfg[gpc_pkg::OC_FN]) begin
            status_pin_out <= battery_good_output;
        end else begin
            status_pin_out <= battery_low_output;
        end
    end
    assign status_pin_oe_n = status_pin_out;

endmodule : gpc_pin_status

// ===== dv/gpc_charger_model.sv
// Charger and battery pack model on the status and insert pins
`timescale 1ns/1ps
module gpc_charger_model (
    input  wire logic status_pin_out,
    input  wire logic status_pin_oe_n,
    input  wire logic battery_insert_pin_out,
    input  wire logic battery_insert_pin_oe_n,
    input  wire logic present,
    input  wire logic chg_req,
    output logic      charging,
    output logic      battery_insert_pin_in
);
    logic status_wire;
    // Pull-up wins on a released pin
    assign status_wire = status_pin_oe_n ? 1'b1 : status_pin_out;
    // Charger stays off while the pin is high
    assign charging = chg_req & ~status_wire;
    // Pack pulls the floating pin low
    assign battery_insert_pin_in = battery_insert_pin_oe_n ? ~present : battery_insert_pin_out;
endmodule : gpc_charger_model

// ===== dv/gpc_pin_status_monitor.sv
// Concurrent checks on the gauge pin block ports
`timescale 1ns/1ps
module gpc_pin_status_monitor (
    input wire logic              clock,
    input wire logic              reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic              charging,
    input wire logic              flash_update_busy,
    input wire logic              sleep_conditions_ok,
    input wire logic              temp_outside_inhibit,
    input wire logic              battery_insert_pin_in,
    input wire logic              battery_insert_pin_out,
    input wire logic              battery_insert_pin_oe_n,
    input wire logic              status_pin_out,
    input wire logic              status_pin_oe_n,
    input wire logic              bus_refuse,
    input wire logic              bus_stretch,
    input wire logic              battery_detected_flag,
    input wire gpc_pkg::gpc_cfg_t cfg,
    input wire gpc_pkg::gpc_ctl_t ctl
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence s_hot;
        cfg.pin_function_code == gpc_pkg::PIN_MODE1 && temp_outside_inhibit;
    endsequence
    property p_inhibit;
        s_hot [*2] |-> ##[1:2] status_pin_out;
    endproperty
    property p_refuse;
        bus_refuse == (flash_update_busy && cfg.flash_update_refuse)
            && bus_stretch == (flash_update_busy && !cfg.flash_update_refuse);
    endproperty
    property p_measure2;
        cfg.pin_function_code == gpc_pkg::PIN_MODE2 && charging |-> !ctl.measure_temp;
    endproperty
    property p_measure;
        cfg.pin_function_code != gpc_pkg::PIN_MODE2 |-> ctl.measure_temp;
    endproperty
    property p_sleep;
        ctl.sleep_enter == (cfg.sleep_allowed && sleep_conditions_ok);
    endproperty
    property p_cfg_hold;
        !(psel && penable && pwrite) |=> $stable(cfg);
    endproperty
    property p_float;
        battery_insert_pin_oe_n && !battery_insert_pin_out;
    endproperty
    property p_open_drain;
        status_pin_oe_n == status_pin_out;
    endproperty
    property p_absent;
        battery_insert_pin_in && !battery_detected_flag |=> !battery_detected_flag;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("status pin low under inhibit");
    a_refuse: assert property (p_refuse) else $error("refuse or stretch wrong");
    a_measure2: assert property (p_measure2) else $error("measures during charge");
    a_measure: assert property (p_measure) else $error("temperature not measured");
    a_sleep: assert property (p_sleep) else $error("sleep request wrong");
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unwritten");
    a_float: assert property (p_float) else $error("insert pin driven");
    a_open_drain: assert property (p_open_drain) else $error("status pin drives high");
    a_absent: assert property (p_absent) else $error("detected with pin high");
endmodule : gpc_pin_status_monitor
bind gpc_pin_status gpc_pin_status_monitor u_mon (.clock, .reset, .psel, .penable, .pwrite,
    .charging, .flash_update_busy, .sleep_conditions_ok, .temp_outside_inhibit,
    .battery_insert_pin_in, .battery_insert_pin_out, .battery_insert_pin_oe_n,
    .status_pin_out, .status_pin_oe_n, .bus_refuse, .bus_stretch, .battery_detected_flag,
    .cfg, .ctl);

// ===== dv/gpc_pin_status_tb.sv
// Testbench for the gauge pin configuration block
`timescale 1ns/1ps
module gpc_pin_status_tb;
    logic clock = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, charging, battery_insert_pin_in, battery_insert_pin_out;
    logic battery_insert_pin_oe_n, status_pin_out, status_pin_oe_n, bus_refuse, bus_stretch;
    logic battery_detected_flag, present = 1'b0, chg_req = 1'b0;
    logic charge_state_threshold_flag = 1'b0, flash_update_busy = 1'b0;
    logic sleep_conditions_ok = 1'b0, temp_outside_inhibit = 1'b0;
    logic temp_inside_hys_band = 1'b1, thermistor_near_open = 1'b0;
    logic [15:0] w;
    logic [7:0] b;
    logic [11:0] addrs [4] = '{12'h000, 12'h004, 12'h010, 12'h020};
    logic [31:0] dflt [4] = '{32'h0000_0979, 32'h0000_0040, 32'h0000_4000, 32'h0};
    gpc_pkg::gpc_cfg_t cfg;
    gpc_pkg::gpc_ctl_t ctl;
    int failures = 0, n_compared = 0, cyc = 0;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
    gpc_pin_status u_dut (.*);
    gpc_charger_model u_chg (.*);
    initial forever #50 clock = ~clock;
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        `CHK({pready, pslverr}, 2'b10)
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask : settle
    // Status pin level: inhibit, then battery-good (still negated), then battery-low
    function automatic logic exp_pin(input logic [15:0] c, input logic f, input logic inh);
        if (inh && c[12:11] == 2'b01) return 1'b1;
        if (c[1]) return ~c[2];
        return c[3] ? f : ~f;
    endfunction : exp_pin
    task automatic report_and_stop;
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(10301));
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, addrs[i], 32'h0);
            `CHK(rd, dflt[i])
        end
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        apb(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h0000_4000)
        for (int i = 0; i < 36; i++) begin
            w = 16'($urandom());
            w[12:11] = 2'(i % 3);
            b = 8'($urandom());
            apb(1'b1, 12'h000, {16'($urandom()), w});
            apb(1'b1, 12'h004, {24'h0, b});
            apb(1'b0, 12'h000, 32'h0);
            {charge_state_threshold_flag, chg_req, flash_update_busy} <= 3'($urandom());
            {sleep_conditions_ok, present} <= 2'($urandom());
            settle;
            `CHK(rd, {16'h0, w})
            `CHK({cfg.reserve_noload_comp, cfg.flash_update_refuse, cfg.pin_function_code,
                cfg.current_wake_level, cfg.sense_range, cfg.adc_ground_choice,
                cfg.profile_select_enable, cfg.sleep_allowed, cfg.capacity_reload_on_full,
                cfg.temp_source_select}, {w[15], w[13:4], w[0]})
            `CHK({cfg.resistance_step_limit, cfg.sleep_wake_charge_add}, b[7:6])
            `CHK(ctl.measure_temp, !(w[12:11] == 2'b10 && charging))
            `CHK(ctl.use_thermistor, w[0])
            `CHK(ctl.sleep_enter, w[5] & sleep_conditions_ok)
            `CHK({bus_refuse, bus_stretch}, {2{flash_update_busy}} & {w[13], ~w[13]})
            `CHK(status_pin_out, exp_pin(w, charge_state_threshold_flag, 1'b0))
            `CHK({battery_detected_flag, battery_insert_pin_oe_n}, 2'b01)
        end
        apb(1'b1, 12'h000, 32'h0000_0979);
        charge_state_threshold_flag <= 1'b0;
        temp_outside_inhibit <= 1'b1;
        temp_inside_hys_band <= 1'b0;
        settle;
        `CHK(status_pin_out, 1'b1)
        // Status word: no battery, inhibit set, not detected, pin high, insert level
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rd, {25'h0, 6'b001101, ~present})
        @(posedge clock);
        temp_outside_inhibit <= 1'b0;
        settle;
        `CHK(status_pin_out, 1'b1)
        @(posedge clock);
        temp_inside_hys_band <= 1'b1;
        settle;
        `CHK(status_pin_out, 1'b0)
        // Termination event gives a one-cycle reload request
        apb(1'b1, 12'h008, 32'h0000_0008);
        #1;
        `CHK(ctl.reload_capacity, 1'b1)
        @(posedge clock);
        #1;
        `CHK(ctl.reload_capacity, 1'b0)
        report_and_stop;
    end
endmodule : gpc_pin_status_tb
